// ---- rtl/i2csw_top.sv ----
// Control logic of a four-channel two-wire bus switch with interrupt combining.
// Assumes open-drain pads outside; all pin inputs are asynchronous to clk_i.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "i2csw_consts.svh"

module i2csw_top #(
  parameter int ADDR_VARIANT = 0
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire i2csw_pkg::i2csw_av_req_t avs_req_i,
  output logic [31:0]                  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  output logic                         irq_o,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_n_o,
  input  wire logic                    ext_rst_n_i,
  input  wire logic                    chan0_irq_in_n_i,
  input  wire logic                    chan1_irq_in_n_i,
  input  wire logic                    chan2_irq_in_n_i,
  input  wire logic                    chan3_irq_in_n_i,
  input  wire logic                    addr_sel_bit0_i,
  input  wire logic                    addr_sel_bit1_i,
  output logic                         int_n_o,
  output logic [3:0]                   downstream_channel_pair_en_o
);
  import i2csw_pkg::*;

  localparam logic [4:0] FIX_PART = (ADDR_VARIANT == 2) ? `I2CSW_FIX_C :
                                    (ADDR_VARIANT == 1) ? `I2CSW_FIX_B :
                                                          `I2CSW_FIX_A;

  i2csw_top_state_t r_reg;
  i2csw_top_state_t r_next;

  logic [8:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic [3:0] irq_n_s;
  logic [1:0] sel_s;
  logic       rst_n_s;

  // All pins pass two flops before any logic reads them
  i2csw_sync #(
    .W   (9),
    .RST (`I2CSW_RST_PINS)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({ext_rst_n_i, addr_sel_bit1_i, addr_sel_bit0_i,
                 chan3_irq_in_n_i, chan2_irq_in_n_i, chan1_irq_in_n_i,
                 chan0_irq_in_n_i, sda_i, scl_i}),
    .sync_o    (pins_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign irq_n_s = pins_s[5:2];
  assign sel_s   = pins_s[7:6];
  assign rst_n_s = pins_s[8];

  // Edges and bus conditions, seen on the synchronised lines
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic bus_rst;
  logic addr_hit;
  logic av_req;
  logic av_take;
  logic [3:0] act;

  assign scl_rise = scl_s & ~r_reg.scl_q;
  assign scl_fall = ~scl_s & r_reg.scl_q;
  assign start_ev = scl_s & r_reg.scl_q & r_reg.sda_q & ~sda_s;
  assign stop_ev  = scl_s & r_reg.scl_q & ~r_reg.sda_q & sda_s;
  assign bus_rst  = ~rst_n_s | r_reg.cfg;
  assign addr_hit = (r_reg.shift[7:1] == {FIX_PART, sel_s});
  assign av_req   = avs_req_i.read | avs_req_i.write;
  assign av_take  = av_req & r_reg.av_ack;
  assign act      = ~irq_n_s;

  // Register image for a bus read
  function automatic logic [31:0] reg_image(input logic [3:0]        ofs,
                                            input i2csw_top_state_t s,
                                            input logic [3:0]        a,
                                            input logic              rn);
    logic [31:0] v;
    v = 32'h0;
    case (ofs)
      `I2CSW_OFS_CTRL: begin
        v[3:0]                               = s.chan_en;
        v[`I2CSW_CT_PEND+3:`I2CSW_CT_PEND]     = s.pend[3:0];
        v[`I2CSW_CT_PVALID]                  = s.pend_valid;
        v[`I2CSW_CT_ACTIVE+3:`I2CSW_CT_ACTIVE] = a;
        v[`I2CSW_CT_EXTRST]                  = ~rn;
      end
      `I2CSW_OFS_STATUS: v[`I2CSW_ST_W-1:0] = s.status;
      `I2CSW_OFS_MASK:   v[`I2CSW_ST_W-1:0] = s.mask;
      `I2CSW_OFS_CFG:    v[0] = s.cfg;
      default:           v = 32'h0;
    endcase
    return v;
  endfunction : reg_image

  always_comb begin
    logic [`I2CSW_ST_W-1:0] ev;
    logic [`I2CSW_ST_W-1:0] clr;
    ev  = '0;
    clr = '0;
    r_next       = r_reg;
    r_next.scl_q = scl_s;
    r_next.sda_q = sda_s;
    r_next.act_q = act;
    r_next.rst_q = rst_n_s;

    // Slave protocol machine, any scl rate down to static
    case (r_reg.st)
      I2CSW_IDLE: begin
        r_next.drive = 1'b0;
      end
      I2CSW_ADDR, I2CSW_WR: begin
        if (scl_rise && !r_reg.byte_done) begin
          r_next.shift  = {r_reg.shift[6:0], sda_s};
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          if (r_reg.bitcnt == 3'h7) begin
            r_next.byte_done = 1'b1;
          end
        end else if (scl_fall && r_reg.byte_done) begin
          r_next.byte_done = 1'b0;
          r_next.bitcnt    = 3'h0;
          if (r_reg.st == I2CSW_WR) begin
            // Each new byte overwrites, so the last one wins
            r_next.pend       = r_reg.shift;
            r_next.pend_valid = 1'b1;
            r_next.drive      = 1'b1;
            r_next.st         = I2CSW_WACK;
          end else if (addr_hit) begin
            r_next.rw    = r_reg.shift[0];
            r_next.drive = 1'b1;
            r_next.st    = I2CSW_AACK;
          end else begin
            r_next.st = I2CSW_IDLE;
          end
        end
      end
      I2CSW_AACK: begin
        if (scl_fall) begin
          if (r_reg.rw) begin
            // Interrupt states sampled at read time
            r_next.shift  = {act, r_reg.chan_en};
            r_next.drive  = ~act[3];
            r_next.bitcnt = 3'h0;
            r_next.st     = I2CSW_RD;
          end else begin
            r_next.drive = 1'b0;
            r_next.st    = I2CSW_WR;
          end
        end
      end
      I2CSW_WACK: begin
        if (scl_fall) begin
          r_next.drive = 1'b0;
          r_next.st    = I2CSW_WR;
        end
      end
      I2CSW_RD: begin
        if (scl_fall) begin
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          if (r_reg.bitcnt == 3'h7) begin
            r_next.drive = 1'b0;
            r_next.st    = I2CSW_RACK;
          end else begin
            r_next.shift = {r_reg.shift[6:0], 1'b0};
            r_next.drive = ~r_reg.shift[6];
          end
        end
      end
      I2CSW_RACK: begin
        if (scl_rise) begin
          r_next.nack = sda_s;
        end else if (scl_fall) begin
          if (r_reg.nack) begin
            r_next.st = I2CSW_IDLE;
          end else begin
            r_next.shift  = {act, r_reg.chan_en};
            r_next.drive  = ~act[3];
            r_next.bitcnt = 3'h0;
            r_next.st     = I2CSW_RD;
          end
        end
      end
      default: begin
        r_next.st    = I2CSW_IDLE;
        r_next.drive = 1'b0;
      end
    endcase

    // Start and stop override the byte machine
    if (start_ev) begin
      r_next.st        = I2CSW_ADDR;
      r_next.bitcnt    = 3'h0;
      r_next.byte_done = 1'b0;
      r_next.drive     = 1'b0;
    end else if (stop_ev) begin
      r_next.st        = I2CSW_IDLE;
      r_next.byte_done = 1'b0;
      r_next.drive     = 1'b0;
      // Switching at stop keeps every line high at connection
      if (r_reg.pend_valid) begin
        r_next.chan_en    = r_reg.pend[3:0];
        r_next.pend_valid = 1'b0;
        ev[`I2CSW_ST_COMMIT] = 1'b1;
      end
    end

    // Reset pin or software deselect: stuck downstream bus recovery
    if (bus_rst) begin
      r_next.st         = I2CSW_IDLE;
      r_next.drive      = 1'b0;
      r_next.byte_done  = 1'b0;
      r_next.bitcnt     = 3'h0;
      r_next.pend_valid = 1'b0;
      r_next.chan_en    = `I2CSW_RST_CHAN;
    end

    ev[`I2CSW_ST_CHIRQ+3:`I2CSW_ST_CHIRQ] = act & ~r_reg.act_q;
    ev[`I2CSW_ST_EXTRST] = r_reg.rst_q & ~rst_n_s;

    // Bus slave: one wait cycle, then the request is taken
    r_next.av_ack = av_req & ~r_reg.av_ack;
    if (av_req && !r_reg.av_ack) begin
      r_next.rdata = avs_req_i.write ? 32'h0 :
                     reg_image(avs_req_i.address, r_reg, act, rst_n_s);
    end
    // Clear only what the read returned, so a later event is not lost
    if (av_take && avs_req_i.read && avs_req_i.address == `I2CSW_OFS_STATUS) begin
      clr = r_reg.rdata[`I2CSW_ST_W-1:0];
    end
    if (av_take && avs_req_i.write) begin
      case (avs_req_i.address)
        `I2CSW_OFS_MASK: r_next.mask = avs_req_i.writedata[`I2CSW_ST_W-1:0];
        `I2CSW_OFS_CFG:  r_next.cfg  = avs_req_i.writedata[0];
        default: begin
        end
      endcase
    end

    // A new event in the clearing cycle survives
    r_next.status = (r_reg.status & ~clr) | ev;
    r_next.irq    = |(r_next.status & r_next.mask);
    r_next.int_n  = &irq_n_s;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_reg            <= '0;
      r_reg.st         <= I2CSW_IDLE;
      r_reg.chan_en    <= `I2CSW_RST_CHAN;
      r_reg.mask       <= `I2CSW_RST_MASK;
      r_reg.cfg        <= `I2CSW_RST_CFG;
      r_reg.scl_q      <= 1'b1;
      r_reg.sda_q      <= 1'b1;
      r_reg.rst_q      <= 1'b1;
      r_reg.int_n      <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_waitrequest_o = av_req & ~r_reg.av_ack;
  assign avs_readdata_o    = r_reg.rdata;
  assign irq_o             = r_reg.irq;
  assign sda_o             = 1'b0;
  assign sda_oe_n_o        = ~r_reg.drive;
  assign int_n_o           = r_reg.int_n;
  // Enables drive external pass switches, traffic is not retimed
  assign downstream_channel_pair_en_o = r_reg.chan_en;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  pin_reset_deselect_a: assert property (
    bus_rst |=> (downstream_channel_pair_en_o == 4'h0) && sda_oe_n_o
  ) else $error("channels not deselected by reset pin");

  power_on_clear_a: assert property (
    $fell(sys_rst_i) |-> (downstream_channel_pair_en_o == 4'h0) &&
                        (r_reg.st == I2CSW_IDLE)
  ) else $error("power-on state not cleared");

  int_and_combine_a: assert property (
    ##1 int_n_o == &$past(irq_n_s)
  ) else $error("combined interrupt is not the AND of inputs");

  commit_at_stop_a: assert property (
    $changed(downstream_channel_pair_en_o) |-> $past(stop_ev) || $past(bus_rst)
  ) else $error("channel selection changed outside stop");

  commit_low_nibble_a: assert property (
    stop_ev && r_reg.pend_valid && !bus_rst |=>
      downstream_channel_pair_en_o == $past(r_reg.pend[3:0])
  ) else $error("selection does not follow low nibble");

  addr_ack_a: assert property (
    r_reg.st == I2CSW_ADDR && scl_fall && r_reg.byte_done && addr_hit &&
    !start_ev && !stop_ev && !bus_rst |=> r_reg.st == I2CSW_AACK && !sda_oe_n_o
  ) else $error("matching address not acknowledged");

  last_byte_kept_a: assert property (
    r_reg.st == I2CSW_WR && scl_fall && r_reg.byte_done &&
    !start_ev && !stop_ev && !bus_rst |=> r_reg.pend == $past(r_reg.shift)
  ) else $error("written byte not kept");

  read_image_a: assert property (
    r_reg.st == I2CSW_AACK && scl_fall && r_reg.rw &&
    !start_ev && !stop_ev && !bus_rst |=>
      r_reg.shift == {$past(act), $past(r_reg.chan_en)}
  ) else $error("read byte does not show interrupt states");

  bus_wait_once_a: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o
  ) else $error("waitrequest held beyond one cycle");

  wait_first_cycle_a: assert property (
    $rose(av_req) |-> avs_waitrequest_o
  ) else $error("new request not held off for one cycle");

  foreign_addr_idle_a: assert property (
    r_reg.st == I2CSW_ADDR && scl_fall && r_reg.byte_done && !addr_hit &&
    !start_ev && !stop_ev && !bus_rst |=> r_reg.st == I2CSW_IDLE && sda_oe_n_o
  ) else $error("foreign address not ignored");

  stop_release_a: assert property (
    stop_ev |=> sda_oe_n_o && (r_reg.st == I2CSW_IDLE)
  ) else $error("data line not released after stop");

  pend_drop_rst_a: assert property (
    bus_rst |=> !r_reg.pend_valid
  ) else $error("pending byte kept through reset pin");

endmodule : i2csw_top

// ---- rtl/i2csw_consts.svh ----
// Offsets, field positions, reset values and address parts of the switch controller.
// Assumes inclusion by bare name from the package and the design modules.
//
// What this block does
// - One upstream bus, four downstream pairs, each connectable on its own.
// - The control byte selects any channel combination, all four included.
// - Four active-low channel interrupt inputs, one per downstream pair.
// - Combined interrupt output is the AND of the four active-low inputs.
// - Reset pin low resets the protocol machine and deselects all channels.
// - Power-on reset gives the same state as the reset pin, glitch free.
// - Two static select inputs give the variable part of the slave address.
// - Fixed address part is a build parameter with three variants.
// - Works at any upstream clock rate from static to fast mode.
// - Low four bits of the written byte enable channels, bit n channel n.
// - A new selection takes effect only after a STOP on the upstream bus.
// - A read returns channel interrupt states 0..3 in bits 4..7, set active.
// - Of several written data bytes only the last one is kept.
`ifndef I2CSW_CONSTS_SVH
`define I2CSW_CONSTS_SVH

// Register byte offsets
`define I2CSW_OFS_CTRL     4'h0
`define I2CSW_OFS_STATUS   4'h4
`define I2CSW_OFS_MASK     4'h8
`define I2CSW_OFS_CFG      4'hc

// Status bit positions
`define I2CSW_ST_COMMIT    0
`define I2CSW_ST_CHIRQ     1
`define I2CSW_ST_EXTRST    5
`define I2CSW_ST_W         6

// Control image field positions
`define I2CSW_CT_PEND      4
`define I2CSW_CT_PVALID    8
`define I2CSW_CT_ACTIVE    9
`define I2CSW_CT_EXTRST    13

// Reset values
`define I2CSW_RST_CHAN     4'h0
`define I2CSW_RST_MASK     6'h00
`define I2CSW_RST_CFG      1'b0
`define I2CSW_RST_PINS     9'h1ff

// Fixed address part per variant, arbitrary values
`define I2CSW_FIX_A        5'h0a
`define I2CSW_FIX_B        5'h0b
`define I2CSW_FIX_C        5'h0c

`endif

// ---- rtl/i2csw_pkg.sv ----
// Types shared by the switch controller modules.
// Assumes the constants header sits next to it.
`include "i2csw_consts.svh"

package i2csw_pkg;

  typedef enum logic [2:0] {
    I2CSW_IDLE = 3'h0,
    I2CSW_ADDR = 3'h1,
    I2CSW_AACK = 3'h3,
    I2CSW_WR   = 3'h2,
    I2CSW_WACK = 3'h6,
    I2CSW_RD   = 3'h7,
    I2CSW_RACK = 3'h5
  } i2csw_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } i2csw_av_req_t;

  typedef struct packed {
    i2csw_state_t st;
    logic [2:0]   bitcnt;
    logic [7:0]   shift;
    logic         byte_done;
    logic         rw;
    logic         nack;
    logic         drive;
    logic [7:0]   pend;
    logic         pend_valid;
    logic [3:0]   chan_en;
    logic         scl_q;
    logic         sda_q;
    logic [3:0]   act_q;
    logic         rst_q;
    logic         av_ack;
    logic [31:0]  rdata;
    logic [`I2CSW_ST_W-1:0] status;
    logic [`I2CSW_ST_W-1:0] mask;
    logic         cfg;
    logic         irq;
    logic         int_n;
  } i2csw_top_state_t;

endpackage : i2csw_pkg

// ---- rtl/i2csw_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are static or slow against clk_i.
`timescale 1ns/100ps

module i2csw_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  import i2csw_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } i2csw_sync_t;

  i2csw_sync_t sync_reg;
  i2csw_sync_t sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = pin_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_reg <= '{s1: RST, s2: RST};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg.s2;

endmodule : i2csw_sync

// ---- tb/i2csw_master_model.sv ----
// Upstream two-wire bus master model for the switch controller bench.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps

module i2csw_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  initial begin
    scl_o      = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Eight clk per bit; data moves mid-low so it never mimics START or STOP
  task automatic put_bit(input logic b, output logic seen);
    tick(2);
    sda_oe_n_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    seen = sda_i;
    scl_o <= 1'b0;
  endtask : put_bit

  task automatic start;
    tick(2);
    sda_oe_n_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask : start

  task automatic stop;
    tick(2);
    sda_oe_n_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_n_o <= 1'b1;
    tick(4);
  endtask : stop

  // Sending 8'hff releases the wire so the same task reads a byte
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] got,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], got[i]);
    end
    put_bit(last, b);
    ack = ~b;
  endtask : xfer
endmodule : i2csw_master_model

// ---- tb/tb_i2csw_top.sv ----
// Self-checking bench for the switch controller top.
// Assumes the master model drives the link; bus registers via Avalon-MM.
`timescale 1ns/100ps
`include "i2csw_consts.svh"

module tb_i2csw_top;
  import i2csw_pkg::*;
  localparam logic [6:0] DEV_ADDR = {`I2CSW_FIX_A, 2'b10};
  logic          clk_i     = 1'b0;
  logic          sys_rst_i = 1'b1;
  i2csw_av_req_t avs_req   = '0;
  logic          ext_rst_n = 1'b1;
  logic [3:0]    chan_n    = 4'hf;
  logic [1:0]    addr_sel  = 2'b10;
  logic [31:0]   avs_rdata;
  logic          avs_wait;
  logic          irq;
  logic          scl;
  logic          m_oe_n;
  logic          d_oe_n;
  logic          d_sda;
  logic          int_n;
  logic [3:0]    en;
  logic [31:0]   rd;
  logic [7:0]    got;
  logic          ack;
  int            num_errors = 0;
  int            n_compared = 0;
  // Pulled-up open-drain wire: low while either side drives it
  wire           sda = m_oe_n & (d_oe_n | d_sda);

  always #5 clk_i = ~clk_i;

  i2csw_top #(.ADDR_VARIANT(0)) u_i2csw_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_req_i(avs_req),
    .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait), .irq_o(irq),
    .scl_i(scl), .sda_i(sda), .sda_o(d_sda), .sda_oe_n_o(d_oe_n), .ext_rst_n_i(ext_rst_n),
    .chan0_irq_in_n_i(chan_n[0]), .chan1_irq_in_n_i(chan_n[1]),
    .chan2_irq_in_n_i(chan_n[2]), .chan3_irq_in_n_i(chan_n[3]),
    .addr_sel_bit0_i(addr_sel[0]), .addr_sel_bit1_i(addr_sel[1]), .int_n_o(int_n),
    .downstream_channel_pair_en_o(en));

  i2csw_master_model u_i2csw_master_model (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // Request held until the rising edge at which waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge clk_i);
    // Only the watchdog ends a wait that never finishes
    while (avs_wait !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_rdata;
    avs_req <= '0;
  endtask : av

  task automatic send(input logic [7:0] b, input logic exp_ack);
    u_i2csw_master_model.xfer(b, 1'b1, got, ack);
    chk(ack, exp_ack);
  endtask : send

  task automatic select(input logic [7:0] b);
    u_i2csw_master_model.start();
    send({DEV_ADDR, 1'b0}, 1'b1);
    send(b, 1'b1);
    u_i2csw_master_model.stop();
    wt(6);
  endtask : select

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // The run needs about 4k cycles; 30k leaves ample room
  initial begin
    #300_000;
    num_errors++;
    end_of_test();
  end

  initial begin
    wt(12);
    sys_rst_i <= 1'b0;
    wt(2);
    chk(en, 4'h0);
    chk(int_n, 1'b1);
    chk(irq, 1'b0);
    av(1'b0, `I2CSW_OFS_MASK, 32'h0, rd);
    chk(rd, 32'h0);
    av(1'b0, 4'h2, 32'h0, rd);
    chk(rd, 32'h0);
    av(1'b1, `I2CSW_OFS_MASK, 32'hff, rd);
    av(1'b0, `I2CSW_OFS_MASK, 32'h0, rd);
    chk(rd, 32'h3f);
    // Two data bytes: selection waits for STOP and keeps the last byte
    u_i2csw_master_model.start();
    send({DEV_ADDR, 1'b0}, 1'b1);
    send(8'hf5, 1'b1);
    send(8'h06, 1'b1);
    wt(6);
    chk(en, 4'h0);
    av(1'b0, `I2CSW_OFS_CTRL, 32'h0, rd);
    chk(rd, (32'h6 << `I2CSW_CT_PEND) | (32'h1 << `I2CSW_CT_PVALID));
    u_i2csw_master_model.stop();
    wt(6);
    chk(en, 4'h6);
    chk(irq, 1'b1);
    av(1'b0, `I2CSW_OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h1);
    wt(3);
    chk(irq, 1'b0);
    // Foreign addresses, including another variant's, are not acknowledged
    for (int i = 0; i < 2; i++) begin
      u_i2csw_master_model.start();
      send({(i == 0) ? (DEV_ADDR ^ 7'h01) : {`I2CSW_FIX_B, 2'b10}, 1'b0}, 1'b0);
      u_i2csw_master_model.stop();
    end
    wt(6);
    chk(en, 4'h6);
    for (int v = 0; v < 16; v++) begin
      select({~v[3:0], v[3:0]});
      chk(en, v[3:0]);
    end
    av(1'b0, `I2CSW_OFS_STATUS, 32'h0, rd);
    for (int c = 0; c < 4; c++) begin
      chan_n <= ~(4'h1 << c);
      wt(6);
      chk(int_n, 1'b0);
    end
    chan_n <= 4'hd;
    wt(6);
    chk(irq, 1'b1);
    av(1'b0, `I2CSW_OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h1e);
    u_i2csw_master_model.start();
    send({DEV_ADDR, 1'b1}, 1'b1);
    u_i2csw_master_model.xfer(8'hff, 1'b1, got, ack);
    u_i2csw_master_model.stop();
    chk(got, 8'h2f);
    chan_n <= 4'hf;
    wt(6);
    chk(int_n, 1'b1);
    // Reset pin in mid-transfer drops the selection and the pending byte
    u_i2csw_master_model.start();
    send({DEV_ADDR, 1'b0}, 1'b1);
    send(8'h03, 1'b1);
    ext_rst_n <= 1'b0;
    wt(6);
    chk(en, 4'h0);
    av(1'b0, `I2CSW_OFS_CTRL, 32'h0, rd);
    chk(rd[`I2CSW_CT_EXTRST], 1'b1);
    ext_rst_n <= 1'b1;
    wt(6);
    u_i2csw_master_model.stop();
    wt(6);
    chk(en, 4'h0);
    av(1'b0, `I2CSW_OFS_STATUS, 32'h0, rd);
    chk(rd[`I2CSW_ST_EXTRST], 1'b1);
    select(8'h09);
    chk(en, 4'h9);
    // Select pins move the address: the old one is ignored, the new one answers
    addr_sel <= 2'b01;
    wt(6);
    u_i2csw_master_model.start();
    send({DEV_ADDR, 1'b0}, 1'b0);
    u_i2csw_master_model.stop();
    u_i2csw_master_model.start();
    send({`I2CSW_FIX_A, 2'b01, 1'b0}, 1'b1);
    send(8'h05, 1'b1);
    u_i2csw_master_model.stop();
    wt(6);
    chk(en, 4'h5);
    end_of_test();
  end
endmodule : tb_i2csw_top
